// file: inc/vmsr_pkg.sv
package vmsr_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses, APB)
  // ----------------------------------------
  localparam logic [15:0] VMSR_OFS_STAT3 = 16'hfe06;
  localparam logic [15:0] VMSR_OFS_FLCTL = 16'hfe08;
  localparam logic [15:0] VMSR_OFS_BREAK_ADDRESS_HIGH = 16'hfe0c;
  localparam logic [15:0] VMSR_OFS_BREAK_ADDRESS_LOW = 16'hfe0d;
  localparam logic [15:0] VMSR_OFS_BRKCTL = 16'hfe0e;
  localparam logic [15:0] VMSR_OFS_PROT = 16'hffcf;
  localparam logic [15:0] VMSR_OFS_OPT = 16'hffd0;
  localparam logic [15:0] VMSR_OFS_WDOG = 16'hffff;
  localparam logic [15:0] VMSR_OFS_IRQ_STAT = 16'hfe10;
  localparam logic [15:0] VMSR_OFS_IRQ_CLR = 16'hfe14;
  localparam logic [15:0] VMSR_OFS_IRQ_EN = 16'hfe18;
  localparam logic [15:0] VMSR_OFS_VEC = 16'hfe1c;
  localparam logic [15:0] VMSR_OFS_NVM_WR = 16'hfe20;
  // ----------------------------------------
  // Monitor ROM ranges
  // ----------------------------------------
  localparam logic [15:0] VMSR_MON0_LO = 16'hfc00;
  localparam logic [15:0] VMSR_MON0_HI = 16'hfdff;
  localparam logic [15:0] VMSR_MON1_LO = 16'hfe10;
  localparam logic [15:0] VMSR_MON1_HI = 16'hffce;
  localparam int VMSR_MON_BYTES = 959;
  // ----------------------------------------
  // Vector high-byte addresses
  // ----------------------------------------
  localparam logic [15:0] VMSR_VEC_CONV = 16'hffde;
  localparam logic [15:0] VMSR_VEC_KEY = 16'hffe0;
  localparam logic [15:0] VMSR_VEC_STX = 16'hffe2;
  localparam logic [15:0] VMSR_VEC_SRX = 16'hffe4;
  localparam logic [15:0] VMSR_VEC_SERR = 16'hffe6;
  localparam logic [15:0] VMSR_VEC_TWI = 16'hffe8;
  localparam logic [15:0] VMSR_VEC_TBOVF = 16'hffec;
  localparam logic [15:0] VMSR_VEC_TBCH1 = 16'hffee;
  localparam logic [15:0] VMSR_VEC_TBCH0 = 16'hfff0;
  localparam logic [15:0] VMSR_VEC_TAOVF = 16'hfff2;
  localparam logic [15:0] VMSR_VEC_TACH1 = 16'hfff4;
  localparam logic [15:0] VMSR_VEC_TACH0 = 16'hfff6;
  localparam logic [15:0] VMSR_VEC_EXT = 16'hfffa;
  localparam logic [15:0] VMSR_VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VMSR_VEC_RESET = 16'hfffe;
  // ----------------------------------------
  // Flag numbers and field positions
  // ----------------------------------------
  localparam int VMSR_NFLAG = 16;
  localparam int VMSR_F_CONV = 15;
  localparam int VMSR_F_KEY = 14;
  localparam int VMSR_F_STX = 13;
  localparam int VMSR_F_SRX = 12;
  localparam int VMSR_F_SERR = 11;
  localparam int VMSR_F_TWI = 10;
  localparam int VMSR_F_TBOVF = 8;
  localparam int VMSR_F_TBCH1 = 7;
  localparam int VMSR_F_TBCH0 = 6;
  localparam int VMSR_F_TAOVF = 5;
  localparam int VMSR_F_TACH1 = 4;
  localparam int VMSR_F_TACH0 = 3;
  localparam int VMSR_F_EXT = 1;
  localparam logic [15:0] VMSR_FLAG_MASK = 16'hfdfa;
  localparam int VMSR_FL_HV = 3;
  localparam int VMSR_FL_MASS = 2;
  localparam int VMSR_FL_ERASE = 1;
  localparam int VMSR_FL_PROG = 0;
  localparam int VMSR_BRK_EN = 7;
  localparam int VMSR_BRK_ACT = 6;
  // ----------------------------------------
  // Reset and blank values
  // ----------------------------------------
  localparam logic [7:0] VMSR_RST_BYTE = 8'h00;
  localparam logic [7:0] VMSR_NVM_BLANK = 8'hff;
  localparam logic [15:0] VMSR_RST_FLAGS = 16'h0000;
  localparam logic [31:0] VMSR_RST_WORD = 32'h0000_0000;
endpackage

// file: inc/vmsr_src_if.sv
`timescale 1ns/100ps
`default_nettype none
// Pending flags into the arbiter, chosen vector out
interface vmsr_src_if;
  logic [15:0] pend;
  logic trap;
  logic any;
  logic [15:0] vec;
  modport arb (input pend, input trap, output any, output vec);
  modport top (output pend, output trap, input any, input vec);
endinterface
`default_nettype wire

// file: logic/vmsr_sync2.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bus of pin levels
module vmsr_sync2 #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: logic/vmsr_arb.sv
`timescale 1ns/100ps
`default_nettype none
// Fixed priority pick: highest vector address wins
module vmsr_arb
  import vmsr_pkg::*;
(
  vmsr_src_if.arb src
);
  // ----------------------------------------
  // Priority chain
  // ----------------------------------------
  always_comb begin
    src.any = 1'b1;
    src.vec = VMSR_VEC_RESET;
    if (src.trap) begin
      src.vec = VMSR_VEC_TRAP;
    end else if (src.pend[VMSR_F_EXT]) begin
      src.vec = VMSR_VEC_EXT;
    end else if (src.pend[VMSR_F_TACH0]) begin
      src.vec = VMSR_VEC_TACH0;
    end else if (src.pend[VMSR_F_TACH1]) begin
      src.vec = VMSR_VEC_TACH1;
    end else if (src.pend[VMSR_F_TAOVF]) begin
      src.vec = VMSR_VEC_TAOVF;
    end else if (src.pend[VMSR_F_TBCH0]) begin
      src.vec = VMSR_VEC_TBCH0;
    end else if (src.pend[VMSR_F_TBCH1]) begin
      src.vec = VMSR_VEC_TBCH1;
    end else if (src.pend[VMSR_F_TBOVF]) begin
      src.vec = VMSR_VEC_TBOVF;
    end else if (src.pend[VMSR_F_TWI]) begin
      src.vec = VMSR_VEC_TWI;
    end else if (src.pend[VMSR_F_SERR]) begin
      src.vec = VMSR_VEC_SERR;
    end else if (src.pend[VMSR_F_SRX]) begin
      src.vec = VMSR_VEC_SRX;
    end else if (src.pend[VMSR_F_STX]) begin
      src.vec = VMSR_VEC_STX;
    end else if (src.pend[VMSR_F_KEY]) begin
      src.vec = VMSR_VEC_KEY;
    end else if (src.pend[VMSR_F_CONV]) begin
      src.vec = VMSR_VEC_CONV;
    end else begin
      src.any = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: logic/vmsr_top.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module vmsr_top
  import vmsr_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] I_IRQ_PIN,
  input wire logic I_SOFT_TRAP,
  input wire logic [7:0] I_RESET_VEC_LO,
  output logic O_IRQ,
  output logic O_IRQ_REQ,
  output logic [15:0] O_VECTOR,
  output logic O_WDOG_CLEAR,
  output logic [15:0] O_BREAK_ADDR,
  output logic O_BREAK_EN,
  output logic [3:0] O_FLASH_CTL
);
  logic [15:0] pins_s;
  logic [15:0] pins_d1_q;
  logic [15:0] flags_q;
  logic [15:0] flag_en_q;
  logic [15:0] flag_rise;
  logic [3:0] flctl_q;
  logic [3:0] flctl_d;
  logic [7:0] break_address_high_q;
  logic [7:0] break_address_low_q;
  logic brk_en_q;
  logic brk_act_q;
  // Non-volatile bytes start blank at power-up and have no reset
  logic [7:0] prot_q = VMSR_NVM_BLANK;
  logic [7:0] opt_q = VMSR_NVM_BLANK;
  logic [15:0] vec_q;
  logic wdog_clr_q;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic [7:0] wb;
  vmsr_src_if src ();

  assign wr_acc = PSEL && PENABLE && PWRITE;
  // Read data is captured in the setup cycle so it stands at the access edge
  assign rd_acc = PSEL && !PENABLE && !PWRITE;
  assign wb = PWDATA[7:0];

  // Monitor ROM decode
  function automatic logic in_mon(input logic [15:0] a);
    in_mon = (a >= VMSR_MON0_LO && a <= VMSR_MON0_HI) ||
      (a >= VMSR_MON1_LO && a <= VMSR_MON1_HI);
  endfunction

  // ----------------------------------------
  // Pin synchroniser and priority pick
  // ----------------------------------------
  vmsr_sync2 #(
    .W(16)
  ) u_sync (
    .i_clk(I_SYS_CLK),
    .i_resetn(I_RESETN),
    .i_async(I_IRQ_PIN),
    .o_sync(pins_s)
  );

  assign src.pend = flags_q & flag_en_q;
  assign src.trap = I_SOFT_TRAP;
  vmsr_arb u_arb (
    .src(src.arb)
  );

  // ----------------------------------------
  // Pending flags, set wins over clear
  // ----------------------------------------
  assign flag_rise = pins_s & ~pins_d1_q & VMSR_FLAG_MASK;

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      pins_d1_q <= VMSR_RST_FLAGS;
    end else begin
      pins_d1_q <= pins_s;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      flags_q <= VMSR_RST_FLAGS;
    end else if (wr_acc && PADDR == VMSR_OFS_IRQ_CLR) begin
      flags_q <= (flags_q & ~PWDATA[15:0]) | flag_rise;
    end else begin
      flags_q <= flags_q | flag_rise;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      flag_en_q <= VMSR_RST_FLAGS;
    end else if (wr_acc && PADDR == VMSR_OFS_IRQ_EN) begin
      flag_en_q <= PWDATA[15:0] & VMSR_FLAG_MASK;
    end
  end

  // Registered vector of the winning source
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      vec_q <= VMSR_VEC_RESET;
    end else begin
      vec_q <= src.vec;
    end
  end

  // ----------------------------------------
  // Flash control with interlocks
  // ----------------------------------------
  always_comb begin
    flctl_d = flctl_q;
    if (wr_acc && PADDR == VMSR_OFS_FLCTL) begin
      flctl_d[VMSR_FL_MASS] = wb[VMSR_FL_MASS];
      flctl_d[VMSR_FL_PROG] = wb[VMSR_FL_PROG] && !wb[VMSR_FL_ERASE];
      flctl_d[VMSR_FL_ERASE] = wb[VMSR_FL_ERASE] && !wb[VMSR_FL_PROG];
      if (wb[VMSR_FL_PROG] && wb[VMSR_FL_ERASE]) begin
        flctl_d[VMSR_FL_PROG] = flctl_q[VMSR_FL_PROG];
        flctl_d[VMSR_FL_ERASE] = flctl_q[VMSR_FL_ERASE];
      end
      flctl_d[VMSR_FL_HV] = wb[VMSR_FL_HV] &&
        (flctl_q[VMSR_FL_HV] || flctl_q[VMSR_FL_PROG] ||
        flctl_q[VMSR_FL_ERASE]);
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      flctl_q <= 4'h0;
    end else begin
      flctl_q <= flctl_d;
    end
  end

  // ----------------------------------------
  // Break registers
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      break_address_high_q <= VMSR_RST_BYTE;
      break_address_low_q <= VMSR_RST_BYTE;
      brk_en_q <= 1'b0;
      brk_act_q <= 1'b0;
    end else if (wr_acc) begin
      if (PADDR == VMSR_OFS_BREAK_ADDRESS_HIGH) begin
        break_address_high_q <= wb;
      end
      if (PADDR == VMSR_OFS_BREAK_ADDRESS_LOW) begin
        break_address_low_q <= wb;
      end
      if (PADDR == VMSR_OFS_BRKCTL) begin
        brk_en_q <= wb[VMSR_BRK_EN];
        brk_act_q <= wb[VMSR_BRK_ACT];
      end
    end
  end

  // ----------------------------------------
  // Non-volatile bytes, no reset
  // ----------------------------------------
  // Only a flash program write with program mode and high voltage on
  always_ff @(posedge I_SYS_CLK) begin
    if (wr_acc && PADDR == VMSR_OFS_NVM_WR && flctl_q[VMSR_FL_PROG] &&
      flctl_q[VMSR_FL_HV]) begin
      prot_q <= prot_q & PWDATA[7:0];
      opt_q <= opt_q & PWDATA[15:8];
    end
  end

  // ----------------------------------------
  // Watchdog clear pulse
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      wdog_clr_q <= 1'b0;
    end else begin
      wdog_clr_q <= wr_acc && PADDR == VMSR_OFS_WDOG;
    end
  end

  // ----------------------------------------
  // APB read mux and error
  // ----------------------------------------
  always_comb begin
    rdata_d = VMSR_RST_WORD;
    addr_ok = 1'b1;
    case (PADDR)
      VMSR_OFS_STAT3: rdata_d[0] = flags_q[VMSR_F_CONV];
      VMSR_OFS_FLCTL: rdata_d[3:0] = flctl_q;
      VMSR_OFS_BREAK_ADDRESS_HIGH: rdata_d[7:0] = break_address_high_q;
      VMSR_OFS_BREAK_ADDRESS_LOW: rdata_d[7:0] = break_address_low_q;
      VMSR_OFS_BRKCTL: rdata_d[7:6] = {brk_en_q, brk_act_q};
      VMSR_OFS_PROT: rdata_d[7:0] = prot_q;
      VMSR_OFS_OPT: rdata_d[7:0] = opt_q;
      VMSR_OFS_WDOG: rdata_d[7:0] = I_RESET_VEC_LO;
      VMSR_OFS_IRQ_STAT: rdata_d[15:0] = flags_q;
      VMSR_OFS_IRQ_CLR: rdata_d = VMSR_RST_WORD;
      VMSR_OFS_IRQ_EN: rdata_d[15:0] = flag_en_q;
      VMSR_OFS_VEC: rdata_d[15:0] = vec_q;
      VMSR_OFS_NVM_WR: rdata_d = VMSR_RST_WORD;
      default: addr_ok = 1'b0;
    endcase
    if (in_mon(PADDR) && PADDR != VMSR_OFS_IRQ_STAT &&
      PADDR != VMSR_OFS_IRQ_CLR && PADDR != VMSR_OFS_IRQ_EN &&
      PADDR != VMSR_OFS_VEC && PADDR != VMSR_OFS_NVM_WR) begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      PRDATA <= VMSR_RST_WORD;
    end else if (rd_acc) begin
      PRDATA <= addr_ok ? rdata_d : VMSR_RST_WORD;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_IRQ = |(flags_q & flag_en_q);
  assign O_IRQ_REQ = src.any;
  assign O_VECTOR = vec_q;
  assign O_WDOG_CLEAR = wdog_clr_q;
  assign O_BREAK_ADDR = {break_address_high_q, break_address_low_q};
  assign O_BREAK_EN = brk_en_q;
  assign O_FLASH_CTL = flctl_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  conv_vector_a: assert property (src.pend == 16'h8000 && !I_SOFT_TRAP
    |=> O_VECTOR == 16'hffde) else $error("conv vector wrong");
  key_vector_a: assert property (src.pend == 16'h4000 && !I_SOFT_TRAP
    |=> O_VECTOR == 16'hffe0) else $error("key vector wrong");
  twi_vector_a: assert property (src.pend == 16'h0400 && !I_SOFT_TRAP
    |=> O_VECTOR == 16'hffe8) else $error("twi vector wrong");
  tb_ovf_vec_a: assert property (src.pend == 16'h0100 && !I_SOFT_TRAP
    |=> O_VECTOR == 16'hffec) else $error("tb vector wrong");
  ta_ch0_vec_a: assert property (src.pend[3] && !src.pend[1] &&
    !I_SOFT_TRAP |=> O_VECTOR == 16'hfff6)
    else $error("ta vector wrong");
  trap_first_a: assert property (I_SOFT_TRAP |=> O_VECTOR == 16'hfffc)
    else $error("trap not first");
  wdog_pulse_a: assert property (wr_acc && PADDR == 16'hffff
    |=> O_WDOG_CLEAR ##1 !O_WDOG_CLEAR)
    else $error("watchdog clear pulse wrong");
  fl_interlock_a: assert property (!(flctl_q[0] && flctl_q[1]))
    else $error("program and erase both set");
  hv_guard_a: assert property ($rose(flctl_q[3]) |->
    $past(flctl_q[0]) || $past(flctl_q[1]))
    else $error("high voltage without mode");
  nvm_hold_a: assert property (wr_acc && PADDR == 16'hffcf
    |=> $stable(prot_q)) else $error("protect byte bus written");

  irq_seen_c: cover property (O_IRQ ##1 wr_acc && PADDR == VMSR_OFS_IRQ_CLR);
  hv_on_c: cover property ($rose(flctl_q[3]));
  brk_set_c: cover property ($rose(O_BREAK_EN));
endmodule
`default_nettype wire

// file: verif/vmsr_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// CPU side bus master: issues APB transfers and waits for the answer
module vmsr_cpu_model (
  input wire logic i_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [15:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // Idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 16'h0000;
    o_pwdata = 32'h0000_0000;
  end

  // One transfer; address and data go stale-inverted once released
  task automatic xfer(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1);
    e = i_pslverr;
    r = i_prdata;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: verif/vmsr_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module vmsr_top_tb_top;
  import vmsr_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, trap, er;
  logic irq, irq_req, wdclr, brk_en;
  logic [15:0] paddr, pin, vec, brk_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rvlo;
  logic [3:0] flctl;
  int n_mismatch = 0;
  int checks = 0;
  int fl [13] = '{15, 14, 13, 12, 11, 10, 8, 7, 6, 5, 4, 3, 1};
  logic [15:0] ev [13] = '{16'hffde, 16'hffe0, 16'hffe2, 16'hffe4,
    16'hffe6, 16'hffe8, 16'hffec, 16'hffee, 16'hfff0, 16'hfff2,
    16'hfff4, 16'hfff6, 16'hfffa};
  logic [15:0] mon [4] = '{16'hfc00, 16'hfdff, 16'hfe30, 16'hffce};

  vmsr_cpu_model u_vmsr_cpu_model (.i_clk(clk), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));
  vmsr_top u_vmsr_top (.I_SYS_CLK(clk), .I_RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .I_IRQ_PIN(pin), .I_SOFT_TRAP(trap), .I_RESET_VEC_LO(rvlo),
    .O_IRQ(irq), .O_IRQ_REQ(irq_req), .O_VECTOR(vec),
    .O_WDOG_CLEAR(wdclr), .O_BREAK_ADDR(brk_addr), .O_BREAK_EN(brk_en),
    .O_FLASH_CTL(flctl));

  // ---------------------------------------
  // Helpers
  // ---------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    u_vmsr_cpu_model.xfer(1'b1, a, d, rd, er);
    // Let the write edge settle before outputs are looked at
    #1;
  endtask
  task automatic rdc(input string nm, input logic [15:0] a,
      input logic [31:0] ex);
    u_vmsr_cpu_model.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(nm, ex, rd);
  endtask
  // Pin rise, held long enough to pass the synchroniser
  task automatic pulse(input logic [15:0] m);
    @(posedge clk);
    pin <= m;
    repeat (4) @(posedge clk);
    pin <= 16'h0000;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("irq_up", 32'h1, {31'h0, irq});
  endtask
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
  endtask
  task automatic test_done();
    $display("counts: checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------
  // Scenarios
  // ---------------------------------------
  task automatic t_reset_vals();
    rdc("stat3", VMSR_OFS_STAT3, 32'h0000_0000);
    rdc("break_address_high", VMSR_OFS_BREAK_ADDRESS_HIGH, 32'h0000_0000);
    rdc("break_address_low", VMSR_OFS_BREAK_ADDRESS_LOW, 32'h0000_0000);
    rdc("brkctl", VMSR_OFS_BRKCTL, 32'h0000_0000);
    rdc("prot", VMSR_OFS_PROT, 32'h0000_00ff);
    rdc("opt", VMSR_OFS_OPT, 32'h0000_00ff);
    chk("vector", 32'h0000_fffe, {16'h0, vec});
    $display("test reset_vals done");
  endtask

  task automatic t_break();
    wr(VMSR_OFS_BREAK_ADDRESS_HIGH, 32'h0000_00a5);
    wr(VMSR_OFS_BREAK_ADDRESS_LOW, 32'h0000_003c);
    wr(VMSR_OFS_BRKCTL, 32'h0000_00ff);
    rdc("break_address_high", VMSR_OFS_BREAK_ADDRESS_HIGH, 32'h0000_00a5);
    rdc("break_address_low", VMSR_OFS_BREAK_ADDRESS_LOW, 32'h0000_003c);
    rdc("brkctl", VMSR_OFS_BRKCTL, 32'h0000_00c0);
    chk("brk_addr", 32'h0000_a53c, {16'h0, brk_addr});
    chk("brk_en", 32'h1, {31'h0, brk_en});
    wr(VMSR_OFS_BRKCTL, 32'h0000_0000);
    chk("brk_en", 32'h0, {31'h0, brk_en});
    $display("test break done");
  endtask

  task automatic t_vectors();
    logic [31:0] b;
    wr(VMSR_OFS_IRQ_EN, 32'h0000_ffff);
    for (int i = 0; i < 13; i++) begin
      b = 32'h1 << fl[i];
      pulse(b[15:0]);
      wait_irq();
      repeat (2) @(posedge clk);
      chk("vector", {16'h0, ev[i]}, {16'h0, vec});
      rdc("vec_reg", VMSR_OFS_VEC, {16'h0, ev[i]});
      rdc("status", VMSR_OFS_IRQ_STAT, b);
      rdc("stat3", VMSR_OFS_STAT3, {31'h0, fl[i] == 15});
      wr(VMSR_OFS_IRQ_CLR, b);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    $display("test vectors done");
  endtask

  task automatic t_mask();
    wr(VMSR_OFS_IRQ_EN, 32'h0000_0000);
    pulse(16'h0020);
    repeat (4) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    chk("req_masked", 32'h0, {31'h0, irq_req});
    rdc("status", VMSR_OFS_IRQ_STAT, 32'h0000_0020);
    wr(VMSR_OFS_IRQ_EN, 32'h0000_0020);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(VMSR_OFS_IRQ_CLR, 32'h0000_0020);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("status", VMSR_OFS_IRQ_STAT, 32'h0000_0000);
    $display("test mask done");
  endtask

  task automatic t_priority();
    wr(VMSR_OFS_IRQ_EN, 32'h0000_ffff);
    pulse(16'h8022);
    wait_irq();
    repeat (2) @(posedge clk);
    chk("vector", 32'h0000_fffa, {16'h0, vec});
    trap <= 1'b1;
    repeat (3) @(posedge clk);
    chk("vector", 32'h0000_fffc, {16'h0, vec});
    trap <= 1'b0;
    wr(VMSR_OFS_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("vector", 32'h0000_fff2, {16'h0, vec});
    wr(VMSR_OFS_IRQ_CLR, 32'h0000_0020);
    repeat (2) @(posedge clk);
    chk("vector", 32'h0000_ffde, {16'h0, vec});
    wr(VMSR_OFS_IRQ_CLR, 32'h0000_8000);
    repeat (2) @(posedge clk);
    chk("vector", 32'h0000_fffe, {16'h0, vec});
    $display("test priority done");
  endtask

  task automatic t_flash();
    wr(VMSR_OFS_FLCTL, 32'h0000_0008);
    rdc("flctl", VMSR_OFS_FLCTL, 32'h0000_0000);
    wr(VMSR_OFS_FLCTL, 32'h0000_0003);
    rdc("flctl", VMSR_OFS_FLCTL, 32'h0000_0000);
    wr(VMSR_OFS_FLCTL, 32'h0000_0001);
    wr(VMSR_OFS_FLCTL, 32'h0000_0009);
    rdc("flctl", VMSR_OFS_FLCTL, 32'h0000_0009);
    chk("flctl_port", 32'h0000_0009, {28'h0, flctl});
    wr(VMSR_OFS_PROT, 32'h0000_0000);
    rdc("prot", VMSR_OFS_PROT, 32'h0000_00ff);
    wr(VMSR_OFS_NVM_WR, 32'h0000_3412);
    rdc("prot", VMSR_OFS_PROT, 32'h0000_0012);
    rdc("opt", VMSR_OFS_OPT, 32'h0000_0034);
    wr(VMSR_OFS_FLCTL, 32'h0000_0000);
    do_reset();
    rdc("prot", VMSR_OFS_PROT, 32'h0000_0012);
    rdc("opt", VMSR_OFS_OPT, 32'h0000_0034);
    $display("test flash done");
  endtask

  task automatic t_wdog();
    rdc("wdog", VMSR_OFS_WDOG, 32'h0000_005c);
    @(posedge clk);
    rvlo <= 8'ha3;
    rdc("wdog", VMSR_OFS_WDOG, 32'h0000_00a3);
    wr(VMSR_OFS_WDOG, 32'h0000_00a5);
    chk("wd_clear", 32'h1, {31'h0, wdclr});
    @(posedge clk);
    #1;
    chk("wd_clear", 32'h0, {31'h0, wdclr});
    wr(VMSR_OFS_WDOG, 32'h0000_0000);
    chk("wd_clear", 32'h1, {31'h0, wdclr});
    $display("test wdog done");
  endtask

  task automatic t_monitor();
    for (int i = 0; i < 4; i++) begin
      wr(mon[i], 32'h0000_0055);
      chk("slverr", 32'h1, {31'h0, er});
      rdc("mon_rd", mon[i], 32'h0000_0000);
      chk("slverr", 32'h1, {31'h0, er});
    end
    $display("test monitor done");
  endtask

  // Clock of 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    pin = 16'h0000;
    trap = 1'b0;
    rvlo = 8'h5c;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset_vals();
    t_break();
    t_vectors();
    t_mask();
    t_priority();
    t_flash();
    t_wdog();
    t_monitor();
    test_done();
  end

  // Hang guard, well beyond the few hundred cycles the tests use
  initial begin
    #(40 * 20000);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end
endmodule
`default_nettype wire
